// ==== abx_consts.vh ====
/*
 * opcode encodings, field positions, quarter codes and reset values for the
 * and / bit-clear / conditional-branch execution block.
 * assumes plain verilog-2005 and inclusion by bare name.
 */
`ifndef ABX_CONSTS_VH
`define ABX_CONSTS_VH

// ============================================================
// opcode matching
`define ABX_OP_AND_HI     6'h05
`define ABX_OP_BCLR_HI    4'h9
`define ABX_OP_BR_HI      4'hE
`define ABX_COND_C_SET    4'h2
`define ABX_COND_N_SET    4'h6
`define ABX_COND_C_CLR    4'h3
`define ABX_COND_N_CLR    4'h7
`define ABX_COND_OV_CLR   4'h5
`define ABX_COND_Z_CLR    4'h1

// ============================================================
// field positions in the instruction word
`define ABX_DEST_BIT      9
`define ABX_ACCESS_BIT    8
`define ABX_BITNUM_LSB    9
`define ABX_FILE_LSB      0

// ============================================================
// addressing
`define ABX_INDEX_LIMIT   8'h5F
`define ABX_ACCESS_HI     8'h80
`define ABX_ACCESS_BANK   4'hF

// ============================================================
// status word bit positions
`define ABX_ST_C          0
`define ABX_ST_Z          2
`define ABX_ST_OV         3
`define ABX_ST_N          4

// ============================================================
// quarter codes (one-hot) and reset values
`define ABX_Q1            5'h01
`define ABX_Q2            5'h02
`define ABX_Q3            5'h04
`define ABX_Q4            5'h08
`define ABX_QNOP          5'h10
`define ABX_NOP_QUARTERS  4'h3
`define ABX_RST_NOP       4'h0
`define ABX_RST_BYTE      8'h00
`define ABX_RST_ADDR      12'h000
`define ABX_RST_PC        21'h000000

`endif

// ==== abx_exec.v ====
/*
 * execution block: accumulator-and-file, file bit clear, and six
 * conditional relative branches, sequenced over four quarters per cycle.
 * assumes the core presents the instruction word and its address with a
 * start pulse in a quarter-one slot, supplies the accumulator, status and
 * bank select, and serves data memory reads combinationally on memRdData.
 * instruction inputs need only be valid in the take slot; the block keeps
 * its own copy until the instruction has finished.
 */
`include "abx_consts.vh"

module abx_exec #(
  parameter PC_W = 21
) (
  input  wire            core_clk,
  input  wire            srst,
  input  wire            instrValid,
  input  wire [15:0]     instrWord,
  input  wire [PC_W-1:0] instrAddr,
  input  wire [7:0]      accIn,
  input  wire [7:0]      statusIn,
  input  wire [3:0]      bankSelectReg,
  input  wire            extendedSetEn,
  input  wire [11:0]     indexBase,
  input  wire [7:0]      memRdData,
  output reg             busy,
  output reg             memRdEn,
  output reg  [11:0]     memAddr,
  output reg             memWrEn,
  output reg  [7:0]      memWrData,
  output reg             accWrEn,
  output reg  [7:0]      accOut,
  output reg             flagWrEn,
  output reg  [7:0]      flagMask,
  output reg  [7:0]      flagValue,
  output reg             pcWrEn,
  output reg  [PC_W-1:0] pcOut,
  output reg             illegalOp
);

  // ============================================================
  // decode helpers
  function isBranch;
    input [15:0] w;
    begin
      isBranch = (w[15:12] == `ABX_OP_BR_HI) &&
                 (w[11:8] == `ABX_COND_C_SET || w[11:8] == `ABX_COND_N_SET ||
                  w[11:8] == `ABX_COND_C_CLR || w[11:8] == `ABX_COND_N_CLR ||
                  w[11:8] == `ABX_COND_OV_CLR || w[11:8] == `ABX_COND_Z_CLR);
    end
  endfunction

  function condMet;
    input [3:0] cc;
    input [7:0] st;
    begin
      case (cc)
        `ABX_COND_C_SET:  condMet = st[`ABX_ST_C];
        `ABX_COND_N_SET:  condMet = st[`ABX_ST_N];
        `ABX_COND_C_CLR:  condMet = ~st[`ABX_ST_C];
        `ABX_COND_N_CLR:  condMet = ~st[`ABX_ST_N];
        `ABX_COND_OV_CLR: condMet = ~st[`ABX_ST_OV];
        `ABX_COND_Z_CLR:  condMet = ~st[`ABX_ST_Z];
        default:          condMet = 1'b0;
      endcase
    end
  endfunction

  function [11:0] fileAddr;
    input [7:0]  f;
    input        a;
    input [3:0]  bank_select_reg;
    input        ext;
    input [11:0] base;
    begin
      if (a)
        fileAddr = {bank_select_reg, f};
      else if (ext && f <= `ABX_INDEX_LIMIT)
        fileAddr = base + {4'h0, f};
      else if (f < `ABX_ACCESS_HI)
        fileAddr = {4'h0, f};
      else
        fileAddr = {`ABX_ACCESS_BANK, f};
    end
  endfunction

  // ============================================================
  // quarter sequencer
  localparam [4:0] Q1   = `ABX_Q1;
  localparam [4:0] Q2   = `ABX_Q2;
  localparam [4:0] Q3   = `ABX_Q3;
  localparam [4:0] Q4   = `ABX_Q4;
  localparam [4:0] QNOP = `ABX_QNOP;
  // flag update mask: only the negative and zero bits are ever written
  localparam [7:0] NZ_MASK = (8'h01 << `ABX_ST_N) | (8'h01 << `ABX_ST_Z);

  reg [4:0]      quarter;
  reg [3:0]      nopCnt;
  reg [15:0]     ir;
  reg [PC_W-1:0] irAddr;
  reg [7:0]      result;
  reg            takeBranch;
  reg            active;
  reg [4:0]      next_quarter;
  reg [3:0]      next_nopCnt;
  reg            next_active;

  wire isAnd   = (ir[15:10] == `ABX_OP_AND_HI);
  wire isBclr  = (ir[15:12] == `ABX_OP_BCLR_HI);
  wire isBr    = isBranch(ir);
  wire destF   = ir[`ABX_DEST_BIT];
  wire [2:0] bitNum = ir[`ABX_BITNUM_LSB+2:`ABX_BITNUM_LSB];
  wire [11:0] effAddr = fileAddr(ir[`ABX_FILE_LSB+7:`ABX_FILE_LSB],
                                 ir[`ABX_ACCESS_BIT], bankSelectReg,
                                 extendedSetEn, indexBase);
  wire signed [PC_W-1:0] offs2 = {{(PC_W-9){ir[7]}}, ir[7:0], 1'b0};
  // offset is sign-extended and doubled; the sum wraps at PC_W bits
  wire [PC_W-1:0] target = irAddr + {{(PC_W-2){1'b0}}, 2'b10}
                         + offs2;
  // bit position comes from the three-bit field above the access bit
  wire [7:0] clearMask = ~(8'h01 << bitNum);

  // ============================================================
  // sequencer next state
  // busy mirrors active so that the core sees a plain registered level
  always @* begin
    next_quarter = quarter;
    next_nopCnt  = nopCnt;
    next_active  = active;
    case (quarter)
      Q1: begin                                     // decode
        if (instrValid) begin
          next_quarter = Q2;
          next_active  = 1'b1;
        end
      end
      Q2: next_quarter = Q3;                        // read
      Q3: next_quarter = Q4;                        // process
      Q4: begin                                     // write
        if (active && isBr && takeBranch) begin
          next_nopCnt  = `ABX_NOP_QUARTERS;
          next_quarter = QNOP;
        end else begin
          next_active  = 1'b0;
          next_quarter = Q1;
        end
      end
      QNOP: begin                                   // flushed cycle
        if (nopCnt == 4'h0) begin
          next_active  = 1'b0;
          next_quarter = Q1;
        end else begin
          next_nopCnt = nopCnt - 4'h1;
        end
      end
      default: begin
        next_active  = 1'b0;
        next_quarter = Q1;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      quarter <= Q1;
      nopCnt  <= `ABX_RST_NOP;
      active  <= 1'b0;
      busy    <= 1'b0;
    end else begin
      quarter <= next_quarter;
      nopCnt  <= next_nopCnt;
      active  <= next_active;
      busy    <= next_active;
    end
  end

  // ============================================================
  // instruction latch
  // word and address are sampled only in the take slot; later changes on
  // instrWord or instrAddr cannot disturb an instruction already under way
  always @(posedge core_clk) begin
    if (srst) begin
      ir     <= 16'h0000;
      irAddr <= {PC_W{1'b0}};
    end else if (quarter == Q1 && instrValid) begin
      ir     <= instrWord;
      irAddr <= instrAddr;
    end
  end

  // ============================================================
  // process quarter
  always @(posedge core_clk) begin
    if (srst) begin
      result     <= `ABX_RST_BYTE;
      takeBranch <= 1'b0;
    end else if (quarter == Q3) begin               // process
      if (isAnd)
        result <= accIn & memRdData;
      else if (isBclr)
        result <= memRdData & clearMask;
      else
        result <= ir[7:0];
      takeBranch <= isBr && condMet(ir[11:8], statusIn);
    end
  end

  // ============================================================
  // data memory port
  always @(posedge core_clk) begin
    if (srst) begin
      memRdEn   <= 1'b0;
      memAddr   <= `ABX_RST_ADDR;
      memWrEn   <= 1'b0;
      memWrData <= `ABX_RST_BYTE;
    end else begin
      // strobes are single-cycle pulses
      memRdEn <= 1'b0;
      memWrEn <= 1'b0;
      if (quarter == Q2 && (isAnd || isBclr)) begin // read
        memAddr <= effAddr;
        memRdEn <= 1'b1;
      end
      // bit clear always writes back; and only when d is set
      if (quarter == Q4 && active && (isBclr || (isAnd && destF))) begin
        memWrEn   <= 1'b1;
        memWrData <= result;
      end
    end
  end

  // ============================================================
  // accumulator and status flags
  function [7:0] nzFlags;
    input [7:0] r;
    begin
      nzFlags = 8'h00;
      nzFlags[`ABX_ST_N] = r[7];
      nzFlags[`ABX_ST_Z] = (r == 8'h00);
    end
  endfunction

  always @(posedge core_clk) begin
    if (srst) begin
      accWrEn   <= 1'b0;
      accOut    <= `ABX_RST_BYTE;
      flagWrEn  <= 1'b0;
      flagMask  <= `ABX_RST_BYTE;
      flagValue <= `ABX_RST_BYTE;
    end else begin
      accWrEn  <= 1'b0;
      flagWrEn <= 1'b0;
      if (quarter == Q4 && active && isAnd) begin
        if (!destF) begin
          accWrEn <= 1'b1;
          accOut  <= result;
        end
        // only n and z change; carry, ov and dc are held
        flagWrEn  <= 1'b1;
        flagMask  <= NZ_MASK;
        flagValue <= nzFlags(result);
      end
      // bit clear and branches never raise flagWrEn
    end
  end

  // ============================================================
  // program counter and decode fault
  always @(posedge core_clk) begin
    if (srst) begin
      pcWrEn    <= 1'b0;
      pcOut     <= {PC_W{1'b0}};
      illegalOp <= 1'b0;
    end else begin
      pcWrEn    <= 1'b0;
      illegalOp <= 1'b0;
      // an unknown word runs its four quarters with no write at all
      if (quarter == Q2 && !isAnd && !isBclr && !isBr)
        illegalOp <= 1'b1;
      // untaken branch: nothing is written in the last quarter
      if (quarter == Q4 && active && isBr && takeBranch) begin
        pcWrEn <= 1'b1;
        pcOut  <= target;
      end
    end
  end

endmodule

// ==== abx_exec_asserts.sv ====
/* port checker for abx_exec.
   assumes it is bound to every abx_exec instance. */
`include "abx_consts.vh"
module abx_exec_chk (
  input logic        core_clk,
  input logic        srst,
  input logic        instrValid,
  input logic [15:0] instrWord,
  input logic [3:0]  bankSelectReg,
  input logic        extendedSetEn,
  input logic [11:0] indexBase,
  input logic        busy,
  input logic        memRdEn,
  input logic [11:0] memAddr,
  input logic        memWrEn,
  input logic [7:0]  memWrData,
  input logic        accWrEn,
  input logic [7:0]  accOut,
  input logic        flagWrEn,
  input logic [7:0]  flagMask,
  input logic [7:0]  flagValue,
  input logic        pcWrEn
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ====================
  // decode at the take edge
  wire       tk = instrValid && !busy;
  wire       isAnd = tk && instrWord[15:10] == `ABX_OP_AND_HI;
  wire       isClr = tk && instrWord[15:12] == `ABX_OP_BCLR_HI;
  wire       isBr = tk && instrWord[15:12] == `ABX_OP_BR_HI;
  wire       fop = isAnd || isClr;
  wire       idx = extendedSetEn && !instrWord[8] && instrWord[7:0] <= 8'h5F;
  wire [7:0] res = memWrEn ? memWrData : accOut;
  // ====================
  a_and_flags: assert property (
    isAnd |-> ##4 flagWrEn && flagMask == 8'h14) else $error("and flags");
  a_flag_value: assert property (
    flagWrEn |-> flagValue[`ABX_ST_N] == res[7]
    && flagValue[`ABX_ST_Z] == (res == 8'h00)) else $error("flag value");
  a_and_dest: assert property (
    isAnd |-> ##4 memWrEn == $past(instrWord[9], 4) && accWrEn == !memWrEn)
    else $error("and destination");
  a_clr_quiet: assert property (
    isClr |-> ##4 memWrEn && !flagWrEn && !accWrEn) else $error("bit clear");
  a_access_bank: assert property (
    fop && !instrWord[8] && !idx |-> ##4 memAddr ==
    {{4{$past(instrWord[7], 4)}}, $past(instrWord[7:0], 4)})
    else $error("access bank address");
  a_bsr_bank: assert property (
    fop && instrWord[8] |-> ##4 memAddr ==
    {$past(bankSelectReg, 4), $past(instrWord[7:0], 4)}) else $error("bank");
  a_indexed_addr: assert property (
    fop && idx |-> ##4 memAddr == $past(indexBase + instrWord[7:0], 4))
    else $error("indexed address");
  a_br_timing: assert property (
    isBr |-> ##4 !flagWrEn && !memWrEn && (pcWrEn ? busy : !busy))
    else $error("branch timing");
  a_read_quarter: assert property (
    fop |-> ##[1:2] memRdEn) else $error("operand read");
  c_taken: cover property (pcWrEn);
  c_acc_dest: cover property (accWrEn);
  c_indexed: cover property (fop && idx);
endmodule
bind abx_exec abx_exec_chk i_chk (.*);

// ==== testbench.sv ====
/* random instruction stream with queued expectations for abx_exec.
   assumes abx_consts.vh on the include path. */
`include "abx_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  reg         core_clk = 0, srst = 1, instrValid = 0, extendedSetEn = 0;
  reg  [15:0] instrWord = 0;
  reg  [20:0] instrAddr = 0;
  reg  [7:0]  accIn = 0, statusIn = 0;
  reg  [3:0]  bankSelectReg = 0;
  reg  [11:0] indexBase = 0;
  wire [7:0]  memRdData, memWrData, accOut, flagMask, flagValue;
  wire        busy, memRdEn, memWrEn, accWrEn, flagWrEn, pcWrEn, illegalOp;
  wire [11:0] memAddr;
  wire [20:0] pcOut;
  reg  [33:0] notes[$];
  integer     seed = 32'h93AD7CBB, error_cnt = 0, samples_checked = 0, i;
  abx_exec i_abx_exec (.*);
  always #5 core_clk = ~core_clk;
  // memory answers with a pattern of its own address
  assign memRdData = memAddr[7:0] ^ {memAddr[11:8], 4'h9};
  task check(input string nm, input [33:0] exp, input [33:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task take(input [1:0] k, input [31:0] v);
    if (notes.size() == 0) check("spare write", {k, ~v}, {k, v});
    else check("write", notes.pop_front(), {k, v});
  endtask
  // ====================
  // watcher: every write strobe and illegalOp consumes the oldest note; memRdEn is not watched
  always @(posedge core_clk) if (!srst) begin
    if (memWrEn) take(0, {12'h0, memAddr, memWrData});
    if (accWrEn) take(1, {24'h0, accOut});
    if (flagWrEn) take(2, {16'h0, flagMask, flagValue & flagMask});
    if (pcWrEn) take(3, {11'h0, pcOut});
    if (illegalOp) take(3, 32'hFFFFFFFF);
  end
  task results;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ====================
  // one instruction: t 0 and, 1 bit clear, 2 branch with condition j,
  // 3 a word that none of the handled opcodes matches
  task run(input [1:0] t, input [2:0] j);
    reg [15:0] w;
    reg [7:0]  a, s, m, r;
    reg [3:0]  b, cc;
    reg [11:0] x, ad;
    reg [20:0] pa;
    reg        e, go;
    integer    n;
    w = $random(seed);
    a = $random(seed);
    s = $random(seed);
    b = $random(seed);
    x = $random(seed);
    e = $random(seed);
    pa = $random(seed) & 21'h1FFFFE;
    case (j)
      0: {cc, go} = {`ABX_COND_C_SET, s[`ABX_ST_C]};
      1: {cc, go} = {`ABX_COND_N_SET, s[`ABX_ST_N]};
      2: {cc, go} = {`ABX_COND_C_CLR, !s[`ABX_ST_C]};
      3: {cc, go} = {`ABX_COND_N_CLR, !s[`ABX_ST_N]};
      4: {cc, go} = {`ABX_COND_OV_CLR, !s[`ABX_ST_OV]};
      default: {cc, go} = {`ABX_COND_Z_CLR, !s[`ABX_ST_Z]};
    endcase
    if (t == 0) w[15:10] = `ABX_OP_AND_HI;
    if (t == 1) w[15:12] = `ABX_OP_BCLR_HI;
    if (t == 2) w[15:8] = {`ABX_OP_BR_HI, cc};
    if (t == 3) w[15:12] = 4'h0;
    if (t == 3) notes.push_back({2'd3, 32'hFFFFFFFF});
    ad = w[8] ? {b, w[7:0]} : (e && w[7:0] <= 8'h5F) ? x + w[7:0]
       : {{4{w[7]}}, w[7:0]};
    m = ad[7:0] ^ {ad[11:8], 4'h9};
    r = t == 0 ? a & m : m & ~(8'h01 << w[11:9]);
    if (t == 0 && !w[9]) notes.push_back({2'd1, 24'h0, r});
    if (t == 1 || (t == 0 && w[9])) notes.push_back({2'd0, 12'h0, ad, r});
    if (t == 0)
      notes.push_back({2'd2, 16'h0, 8'h14, 3'h0, r[7], 1'b0, r == 8'h00, 2'h0});
    if (t == 2 && go)
      notes.push_back({2'd3, 11'h0, pa + 21'd2 + {{12{w[7]}}, w[7:0], 1'b0}});
    @(posedge core_clk);
    {instrWord, accIn, statusIn, bankSelectReg} <= {w, a, s, b};
    {indexBase, extendedSetEn, instrAddr, instrValid} <= {x, e, pa, 1'b1};
    @(posedge core_clk);
    instrValid <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n = n + 1;
    end while (busy !== 1'b0 && n < 20);
    check("busy span", (t == 2 && go) ? 8 : 4, n);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (i = 0; i < 96; i = i + 1) begin
      run(i < 90 ? i % 3 : 3, (i / 3) % 6);
      $display("test %0d done", i);
    end
    repeat (4) @(posedge core_clk);
    check("pending notes", 0, notes.size());
    results();
  end
  initial begin
    #30000;
    error_cnt = error_cnt + 1;
    results();
  end
endmodule
